// ### dv/acr_core_model.sv
// Behavioural analog core: vin_pos alone, or difference of two test voltages when differential
`timescale 1ns/1ns
module acr_core_model (
  input wire logic pclk,
  input wire logic conv_power,
  input wire logic conv_differential,
  input wire logic [9:0] vin_pos,
  input wire logic [9:0] vin_neg,
  output logic [9:0] core_magnitude,
  output logic core_negative
);
  logic [9:0] mag_q = 10'h000;
  logic neg_q = 1'b0;
  assign core_magnitude = mag_q;
  assign core_negative = neg_q;
  always @(posedge pclk) begin
    if (!conv_power) begin
      // Unpowered core output is junk, so it keeps moving
      mag_q <= ~mag_q;
    end else begin
      neg_q <= conv_differential && vin_neg > vin_pos;
      mag_q <= !conv_differential ? vin_pos :
        (vin_neg > vin_pos ? vin_neg - vin_pos : vin_pos - vin_neg);
    end
  end
endmodule

// ### dv/acr_ctrl_checker.sv
// Port assertions for the converter control block
`timescale 1ns/1ns
module acr_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic conv_irq,
  input wire logic conv_power,
  input wire logic conv_sample
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire en_wr = psel && penable && pwrite && pstrb[0] && paddr == 8'h18;
  bus_wait_a: assert property (psel && penable |-> pready) else $error("pready late");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  irq_gate_a: assert property (conv_irq |-> global_irq_enable) else $error("irq gate");
  sample_power_a: assert property (conv_sample |-> conv_power) else $error("unpowered");
  sample_pulse_a: assert property (conv_sample |=> !conv_sample) else $error("long");
  power_on_a: assert property (en_wr && pwdata[7] |-> ##[1:2] conv_power)
    else $error("no power");
  power_off_a: assert property (en_wr && !pwdata[7] |-> ##[1:2] !conv_power)
    else $error("still powered");
  power_hold_a: assert property ($fell(conv_power) |-> $past(en_wr) || $past(en_wr, 2))
    else $error("power lost");
  cover property (conv_sample);
  cover property (conv_irq);
  cover property (pslverr);
endmodule
bind acr_converter_ctrl acr_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .conv_irq(conv_irq), .conv_power(conv_power), .conv_sample(conv_sample));

// ### dv/testbench.sv
// Directed register-level testbench for the converter control block
`timescale 1ns/1ns
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] trigger_in = 6'h00;
  logic irq_vector_ack = 1'b0, global_irq_enable = 1'b1;
  logic [9:0] vin_pos = 10'h2A5, vin_neg = 10'h000, core_magnitude;
  logic pready, pslverr, conv_irq, core_negative, conv_power, conv_sample;
  logic conv_differential, conv_gain_20x, conv_bipolar;
  logic [2:0] conv_pos_input, conv_neg_input, conv_reference;
  wire [7:0] mux_now = {conv_pos_input, conv_neg_input, conv_differential, conv_gain_20x};
  logic [7:0] mux_tab [16] = '{8'h18, 8'h38, 8'h58, 8'h78, 8'h4A, 8'h4B, 8'h4E, 8'h4F,
    8'h02, 8'h03, 8'h06, 8'h07, 8'hB8, 8'hD8, 8'hFC, 8'h98};
  int failures = 0, n_checks = 0, cyc = 0, d;
  acr_converter_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in), .conv_irq(conv_irq),
    .irq_vector_ack(irq_vector_ack), .global_irq_enable(global_irq_enable),
    .core_magnitude(core_magnitude), .core_negative(core_negative), .conv_power(conv_power),
    .conv_sample(conv_sample), .conv_pos_input(conv_pos_input), .conv_bipolar(conv_bipolar),
    .conv_neg_input(conv_neg_input), .conv_differential(conv_differential),
    .conv_gain_20x(conv_gain_20x), .conv_reference(conv_reference));
  acr_core_model core_u (.pclk(pclk), .conv_power(conv_power), .vin_pos(vin_pos),
    .conv_differential(conv_differential), .vin_neg(vin_neg),
    .core_magnitude(core_magnitude), .core_negative(core_negative));
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v,
                      output logic [7:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b1, a, v, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask
  // Waits for the interrupt; the window catches wrong tick counts
  task automatic await_irq(input int lo, input int hi);
    int c = 0;
    while (conv_irq !== 1'b1 && c < 3000) begin
      @(negedge pclk);
      c++;
    end
    chk({7'h0, c >= lo && c <= hi}, 8'h01);
  endtask
  task automatic conv(input logic [7:0] ctl, input int lo, input int hi);
    wr(8'h18, ctl);
    await_irq(lo, hi);
    wr(8'h18, ctl & 8'hBF | 8'h10);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 3; a < 8; a++) rd(8'(a * 4), 8'h00);
    rd(8'h00, 8'h00);
    chk({7'h0, err}, 8'h01);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00);
    pstrb <= 4'h0;
    wr(8'h1C, 8'h20);
    pstrb <= 4'hF;
    rd(8'h1C, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'hE7);
    wr(8'h0C, 8'h00);
    $display("registers done");
    conv(8'hC8, 48, 54);
    wr(8'h1C, 8'h20);
    rd(8'h10, 8'h40);
    rd(8'h14, 8'hA9);
    wr(8'h1C, 8'h00);
    for (int k = 0; k < 8; k++) begin
      d = k < 2 ? 2 : 1 << k;
      conv(8'hC8 | 8'(k), 12 * d, 13 * d + 4);
    end
    rd(8'h10, 8'hA5);
    vin_pos <= 10'h155;
    conv(8'hC8, 20, 30);
    rd(8'h14, 8'h02);
    conv(8'hC8, 20, 30);
    rd(8'h10, 8'h55);
    rd(8'h14, 8'h01);
    $display("timing and alignment done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h1C, 8'(k));
      conv(8'hC8, 20, 30);
      @(negedge pclk);
      chk(mux_now, mux_tab[k]);
    end
    wr(8'h1C, 8'h01);
    wr(8'h18, 8'hC8);
    rd(8'h18, 8'hC8);
    wr(8'h18, 8'h88);
    wr(8'h1C, 8'h02);
    @(negedge pclk);
    chk(mux_now, 8'h38);
    rd(8'h18, 8'hC8);
    await_irq(0, 30);
    rd(8'h18, 8'h98);
    global_irq_enable <= 1'b0;
    @(negedge pclk);
    chk({7'h0, conv_irq}, 8'h00);
    @(posedge pclk);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge pclk);
    irq_vector_ack <= 1'b0;
    rd(8'h18, 8'h88);
    wr(8'h18, 8'hC8);
    wr(8'h18, 8'h00);
    repeat (80) @(posedge pclk);
    rd(8'h18, 8'h00);
    conv(8'hC8, 48, 54);
    $display("channel and control done");
    wr(8'h1C, 8'h06);
    vin_pos <= 10'h100;
    vin_neg <= 10'h180;
    conv(8'hC8, 20, 30);
    rd(8'h10, 8'hFF);
    rd(8'h14, 8'h03);
    wr(8'h0C, 8'h80);
    conv(8'hC8, 20, 30);
    rd(8'h10, 8'hC0);
    rd(8'h14, 8'h03);
    chk({7'h0, conv_bipolar}, 8'h01);
    wr(8'h0C, 8'h00);
    conv(8'hE8, 20, 30);
    conv(8'hA8, 8, 30);
    wr(8'h18, 8'h88);
    await_irq(0, 30);
    wr(8'h18, 8'h98);
    wr(8'h0C, 8'h01);
    wr(8'h18, 8'hA8);
    for (int k = 1; k < 7; k++) begin
      wr(8'h0C, 8'(k));
      trigger_in <= 6'(1 << (k - 1));
      conv(8'hA8, 18, 30);
      trigger_in <= 6'h00;
    end
    wr(8'h1C, 8'h40);
    conv(8'hC8, 48, 54);
    chk({5'h0, conv_reference}, 8'h01);
    $display("modes and triggers done");
    tally_and_finish;
  end
endmodule

// ### verilog/acr_converter_ctrl.sv
// Control and result registers of a 10-bit converter, APB slave
// Operation
// R1 - Left-adjust bit selects result byte alignment
// R2 - Alignment change remaps result bytes immediately
// R3 - Codes 0-3 pins, 12 bandgap, 13 ground, 15 temp
// R4 - Codes 4-11 differential pairs, odd codes 20x
// R5 - Channel change waits for running conversion
// R6 - Enable powers converter, disable aborts conversion
// R7 - Start bit begins single or first conversion
// R8 - First conversion 25 clocks, later 13
// R9 - Start reads busy, writing zero ignored
// R10 - Auto trigger on selected source rising edge
// R11 - Done flag set when result updated
// R12 - Done flag cleared by vector or write one
// R13 - Interrupt when flag, enable, global enable
// R14 - Divider codes give 2,2,4..128 system clocks
// R15 - Low byte read locks result until high read
// R16 - Result bit placement per alignment
// R17 - Bipolar mode gives two's complement result
// R18 - Unipolar negative difference saturates result
// R19 - Unipolar 10 bits, bipolar 9 plus sign
// R20 - Trigger codes: free run, then six sources
// R21 - Reference change deferred, next takes 25
// R22 - Free running restarts after each completion
`timescale 1ns/1ns
module acr_converter_ctrl
  import acr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACR_ADDR_W-1:0] paddr,
  input wire logic [ACR_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ACR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] trigger_in,
  input wire logic irq_vector_ack,
  input wire logic global_irq_enable,
  output logic conv_irq,
  input wire logic [9:0] core_magnitude,
  input wire logic core_negative,
  output logic conv_power,
  output logic conv_sample,
  output logic [2:0] conv_pos_input,
  output logic [2:0] conv_neg_input,
  output logic conv_differential,
  output logic conv_gain_20x,
  output logic conv_bipolar,
  output logic [2:0] conv_reference
);

  typedef struct packed {
    logic enable;
    logic busy;
    logic auto_trig;
    logic done_flag;
    logic irq_en;
    logic [2:0] div_sel;
    logic bipolar;
    logic cmp_mux;
    logic polarity_rev;
    logic [2:0] trig_sel;
    logic left_adj;
    logic [2:0] ref_sel;
    logic [3:0] chan_sel;
    logic [7:0] mux_act;
    logic [2:0] ref_act;
    logic bipolar_act;
    logic first;
    logic [6:0] pre_cnt;
    logic [4:0] tick_cnt;
    logic [9:0] result;
    logic lock;
    logic trig_prev;
    logic sample;
    logic [7:0] rdata;
  } acr_state_t;

  acr_state_t st_q;
  acr_state_t st_d;

  // Mask of prescaler counter bits that must all be one for a converter tick
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = 7'h01;
    if (sel > 3'h1) begin
      m = 7'(({7'h00, 1'b1} << sel) - 8'h01); // R14
    end
    return m;
  endfunction

  // Multiplexer decode: {differential, gain20x, positive, negative}
  function automatic logic [7:0] chan_decode(input logic [3:0] c);
    logic [7:0] r;
    r = {2'b00, ACR_IN_NONE, ACR_IN_NONE};
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        r = {2'b00, 1'b0, c[1:0], ACR_IN_GND}; // R3
      end
      4'h4, 4'h5: begin
        r = {1'b1, c[0], 3'h2, 3'h2}; // R4
      end
      4'h6, 4'h7: begin
        r = {1'b1, c[0], 3'h2, 3'h3}; // R4
      end
      4'h8, 4'h9: begin
        r = {1'b1, c[0], 3'h0, 3'h0}; // R4
      end
      4'hA, 4'hB: begin
        r = {1'b1, c[0], 3'h0, 3'h1}; // R4
      end
      4'hC: begin
        r = {2'b00, ACR_IN_BGAP, ACR_IN_GND}; // R3
      end
      4'hD: begin
        r = {2'b00, ACR_IN_GND, ACR_IN_GND}; // R3
      end
      4'hF: begin
        r = {2'b00, ACR_IN_TEMP, ACR_IN_GND}; // R3
      end
      default: begin
        r = {2'b00, ACR_IN_NONE, ACR_IN_NONE};
      end
    endcase
    return r;
  endfunction

  // Selected auto-trigger source; free running and code 7 pick nothing
  // A case, not an index, so no code can select outside the six sources
  function automatic logic trig_pick(input logic [2:0] sel, input logic [5:0] src);
    logic t;
    t = 1'b0;
    case (sel)
      3'h1: t = src[0];
      3'h2: t = src[1];
      3'h3: t = src[2];
      3'h4: t = src[3];
      3'h5: t = src[4];
      3'h6: t = src[5];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Result coding from the core's magnitude and sign
  function automatic logic [9:0] code_result(input logic [9:0] mag, input logic neg,
                                             input logic bip, input logic diff);
    logic [9:0] half;
    logic [9:0] r;
    half = {1'b0, mag[9:1]};
    r = mag;
    if (diff && bip) begin
      r = neg ? 10'(~half + 10'h001) : half; // R17 R19
    end else if (diff && neg) begin
      r = ACR_RES_SAT; // R18
    end
    return r;
  endfunction

  // Register read image; result alignment follows the live left-adjust bit
  function automatic logic [7:0] read_byte(input logic [2:0] idx, input acr_state_t s);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      ACR_IDX_CTRL_B: begin
        b = {s.bipolar, s.cmp_mux, s.polarity_rev, 2'b00, s.trig_sel};
      end
      ACR_IDX_RES_LO: begin
        b = s.left_adj ? {s.result[1:0], 6'h00} : s.result[7:0]; // R1 R2 R16
      end
      ACR_IDX_RES_HI: begin
        b = s.left_adj ? s.result[9:2] : {6'h00, s.result[9:8]}; // R1 R2 R16
      end
      ACR_IDX_CTRL_A: begin
        b = {s.enable, s.busy, s.auto_trig, s.done_flag, s.irq_en, s.div_sel}; // R9
      end
      ACR_IDX_IN_SEL: begin
        b = {s.ref_sel[1], s.ref_sel[0], s.left_adj, s.ref_sel[2], s.chan_sel};
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction

  logic addr_ok;
  logic [2:0] idx;
  logic setup_rd;
  logic wr;
  logic [7:0] wb;
  logic tick;
  logic [4:0] target;
  logic complete;
  logic abort;
  logic start;
  logic trig_now;
  logic [7:0] dec;
  logic [6:0] mask;
  logic trig_edge;

  assign idx = paddr[4:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ACR_ADDR_W-1:5] == 3'h0) &&
                   (idx >= ACR_IDX_CTRL_B);
  // Zero-wait slave: access phase always completes in its first cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = {24'h000000, st_q.rdata};
  assign conv_irq = st_q.done_flag & st_q.irq_en & global_irq_enable; // R13
  assign conv_power = st_q.enable; // R6
  assign conv_sample = st_q.sample;
  // Selects come straight from flops, so the multiplexer never sees decode glitches
  assign dec = st_q.mux_act;
  assign conv_differential = dec[7];
  assign conv_gain_20x = dec[6];
  assign conv_pos_input = dec[5:3];
  assign conv_neg_input = dec[2:0];
  assign conv_bipolar = st_q.bipolar_act;
  assign conv_reference = st_q.ref_act;

  always_comb begin
    st_d = st_q;
    st_d.sample = 1'b0;
    setup_rd = psel & ~penable & ~pwrite & addr_ok;
    wr = psel & penable & pwrite & addr_ok & pstrb[0];
    wb = pwdata[7:0];
    abort = 1'b0;
    start = 1'b0;
    complete = 1'b0;
    target = st_q.first ? ACR_CYC_FIRST : ACR_CYC_NORMAL; // R8 R21

    // Read data is captured in the setup cycle so that it is a flop at the access edge
    if (psel & ~penable) begin
      st_d.rdata = addr_ok ? read_byte(idx, st_q) : 8'h00;
    end
    // Lock taken with the same capture, so a result landing later cannot split the pair
    if (setup_rd && idx == ACR_IDX_RES_LO) begin
      st_d.lock = 1'b1; // R15
    end
    if (setup_rd && idx == ACR_IDX_RES_HI) begin
      st_d.lock = 1'b0; // R15
    end

    if (wr) begin
      case (idx)
        ACR_IDX_CTRL_A: begin
          st_d.enable = wb[ACR_A_EN]; // R6
          st_d.auto_trig = wb[ACR_A_ATE];
          st_d.irq_en = wb[ACR_A_IE];
          st_d.div_sel = wb[2:0];
          if (wb[ACR_A_FLAG]) begin
            st_d.done_flag = 1'b0; // R12
          end
          // Enable and start may arrive in one write; that conversion is a first one
          if (!wb[ACR_A_EN]) begin
            abort = 1'b1; // R6
          end else if (!st_q.enable) begin
            st_d.first = 1'b1; // R8
          end
          if (wb[ACR_A_EN] && wb[ACR_A_START] && !st_q.busy) begin
            start = 1'b1; // R7 R9
          end
        end
        ACR_IDX_CTRL_B: begin
          st_d.bipolar = wb[ACR_B_BIN]; // R17
          st_d.cmp_mux = wb[ACR_B_CMP];
          st_d.polarity_rev = wb[ACR_B_IPR];
          st_d.trig_sel = wb[2:0]; // R20
        end
        ACR_IDX_IN_SEL: begin
          st_d.left_adj = wb[ACR_S_LADJ]; // R2
          st_d.ref_sel = {wb[ACR_S_REF2], wb[ACR_S_REF1], wb[ACR_S_REF0]};
          st_d.chan_sel = wb[3:0];
        end
        default: begin
        end
      endcase
    end

    if (irq_vector_ack) begin
      st_d.done_flag = 1'b0; // R12
    end

    // Prescaler runs only while powered and restarts from zero, so tick phase is repeatable
    st_d.pre_cnt = st_d.enable ? 7'(st_q.pre_cnt + 7'h01) : 7'h00;
    mask = div_mask(st_q.div_sel); // R14
    tick = st_q.enable && ((st_q.pre_cnt & mask) == mask);

    // A disable outranks a completion landing in the same cycle
    if (abort) begin
      st_d.busy = 1'b0; // R6
      st_d.tick_cnt = 5'h00;
    end else if (st_q.busy && tick) begin
      if (st_q.tick_cnt == 5'(target - 5'h01)) begin
        complete = 1'b1;
        st_d.busy = 1'b0; // R9
        st_d.first = 1'b0;
        st_d.done_flag = 1'b1; // R11
        // A locked pair drops this result; the flag still reports the completion
        if (!st_q.lock) begin
          st_d.result = code_result(core_magnitude, core_negative,
                                    st_q.bipolar_act, dec[7]); // R15
        end
      end else begin
        st_d.tick_cnt = 5'(st_q.tick_cnt + 5'h01);
      end
    end

    // Trigger edge is judged on the selected source; code zero selects none
    trig_now = trig_pick(st_q.trig_sel, trigger_in); // R20
    trig_edge = trig_now && !st_q.trig_prev;
    // Edge memory follows the selected source, so a switch from a low source to a high one reads as an edge
    st_d.trig_prev = trig_now;
    if (st_q.enable && !abort && st_q.auto_trig && trig_edge && !st_q.busy) begin
      start = 1'b1; // R10
    end
    if (complete && st_q.auto_trig && st_q.trig_sel == ACR_TS_FREE && !abort) begin
      start = 1'b1; // R22
    end

    // Selections are latched only at a start, so rewrites mid-conversion wait
    if (start) begin
      st_d.busy = 1'b1; // R9
      st_d.tick_cnt = 5'h00;
      st_d.sample = 1'b1;
      st_d.mux_act = chan_decode(st_q.chan_sel); // R3 R4 R5
      st_d.bipolar_act = st_q.bipolar;
      st_d.ref_act = st_q.ref_sel; // R21
      if (st_q.ref_sel != st_q.ref_act) begin
        st_d.first = 1'b1; // R21
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Every field but mux_act clears; the multiplexer rests on pin 0 against ground
      st_q <= '{
        enable: 1'b0,
        busy: 1'b0,
        auto_trig: 1'b0,
        done_flag: 1'b0,
        irq_en: 1'b0,
        div_sel: 3'h0,
        bipolar: 1'b0,
        cmp_mux: 1'b0,
        polarity_rev: 1'b0,
        trig_sel: 3'h0,
        left_adj: 1'b0,
        ref_sel: 3'h0,
        chan_sel: 4'h0,
        mux_act: {2'b00, 3'h0, ACR_IN_GND},
        ref_act: 3'h0,
        bipolar_act: 1'b0,
        first: 1'b0,
        pre_cnt: 7'h00,
        tick_cnt: 5'h00,
        result: ACR_RST_RES,
        lock: 1'b0,
        trig_prev: 1'b0,
        sample: 1'b0,
        rdata: ACR_RST_BYTE
      };
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ### verilog/acr_pkg.sv
// Register map, field layout and timing counts of the converter control block
package acr_pkg;
  localparam int ACR_DATA_W = 32;
  localparam int ACR_ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [2:0] ACR_IDX_CTRL_B = 3'h3;
  localparam logic [2:0] ACR_IDX_RES_LO = 3'h4;
  localparam logic [2:0] ACR_IDX_RES_HI = 3'h5;
  localparam logic [2:0] ACR_IDX_CTRL_A = 3'h6;
  localparam logic [2:0] ACR_IDX_IN_SEL = 3'h7;
  // converter_control_a fields
  localparam int ACR_A_EN = 7;
  localparam int ACR_A_START = 6;
  localparam int ACR_A_ATE = 5;
  localparam int ACR_A_FLAG = 4;
  localparam int ACR_A_IE = 3;
  // converter_control_b fields
  localparam int ACR_B_BIN = 7;
  localparam int ACR_B_CMP = 6;
  localparam int ACR_B_IPR = 5;
  // input_select fields
  localparam int ACR_S_REF1 = 7;
  localparam int ACR_S_REF0 = 6;
  localparam int ACR_S_LADJ = 5;
  localparam int ACR_S_REF2 = 4;
  // Reset values
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [9:0] ACR_RST_RES = 10'h000;
  // Converter clock counts per conversion
  localparam logic [4:0] ACR_CYC_FIRST = 5'h19;
  localparam logic [4:0] ACR_CYC_NORMAL = 5'h0D;
  // Free-running trigger code and saturated unipolar value
  localparam logic [2:0] ACR_TS_FREE = 3'h0;
  localparam logic [9:0] ACR_RES_SAT = 10'h3FF;
  // Input codes presented to the analog multiplexer
  localparam logic [2:0] ACR_IN_TEMP = 3'h4;
  localparam logic [2:0] ACR_IN_BGAP = 3'h5;
  localparam logic [2:0] ACR_IN_GND = 3'h6;
  localparam logic [2:0] ACR_IN_NONE = 3'h7;
endpackage
